// [hw/ilv_pkg.sv]
// ilv_pkg: shared constants for the interleaved converter output and reload block
// assumes a 200 MHz ref_clk; all counts derive from it
package ilv_pkg;
    localparam int ILV_SAMPLE_W = 12;
    localparam int ILV_CLK_PERIOD_PS = 5000;
    // reload completes within this time after the reset pin rises
    localparam longint ILV_RELOAD_MAX_MS = 600;
    localparam longint ILV_RELOAD_CYCLES = (ILV_RELOAD_MAX_MS * 64'd1000000000) / ILV_CLK_PERIOD_PS;
    // least time the reset pin must stay low, held by the far side
    localparam int ILV_RST_MIN_NS = 200;
    localparam int ILV_RST_MIN_CYCLES = (ILV_RST_MIN_NS * 1000 + ILV_CLK_PERIOD_PS - 1) / ILV_CLK_PERIOD_PS;
    // coefficient word loaded from nonvolatile store
    localparam int ILV_COEF_W = 16;
    localparam int ILV_COEF_FRAC = 14;
    localparam logic [ILV_COEF_W-1:0] ILV_COEF_UNITY = 16'h4000;
    localparam int ILV_CFG_WORDS = 4;
    localparam int ILV_CFG_AW = 2;
    localparam logic [ILV_CFG_AW-1:0] ILV_CFG_GAIN_A = 2'h0;
    localparam logic [ILV_CFG_AW-1:0] ILV_CFG_GAIN_B = 2'h1;
    localparam logic [ILV_CFG_AW-1:0] ILV_CFG_OFS_B = 2'h2;
    localparam logic [ILV_CFG_AW-1:0] ILV_CFG_SKEW_B = 2'h3;
    typedef enum logic [2:0] {
        ILV_ST_HOLD = 3'b001,
        ILV_ST_LOAD = 3'b010,
        ILV_ST_RUN  = 3'b100
    } ilv_state_t;
endpackage

// [hw/ilv_cfg_mem.sv]
// ilv_cfg_mem: processing-logic configuration memory, registered read port
// assumes the loader writes it word by word before the datapath reads it
`timescale 1ns/1ps
`default_nettype none
module ilv_cfg_mem #(
    parameter int DW = 16,
    parameter int AW = 2
) (
    // clock
    input wire logic ref_clk,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // read port
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem_reg [0:(1<<AW)-1];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data <= mem_reg[rd_addr];
    end
endmodule
`default_nettype wire

// [hw/ilv_core.sv]
// ilv_core: two-channel interleaved converter digital side: channel clocking,
// mismatch correction, dual half-rate output buses and the reset-driven reload
// assumes sample inputs are synchronous to ref_clk (the encode clock)
`timescale 1ns/1ps
`default_nettype none
module ilv_core
    import ilv_pkg::*;
#(
    parameter int SAMPLE_W = ILV_SAMPLE_W,
    parameter longint RELOAD_CYCLES = ILV_RELOAD_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // reset pin from the system, active low
    input wire logic reload_rst_n,
    // converter cores, offset binary, one sample per channel clock edge
    input wire logic [SAMPLE_W-1:0] conv_a_data,
    input wire logic [SAMPLE_W-1:0] conv_b_data,
    // nonvolatile configuration store
    output logic cfg_rd_req,
    output logic [ILV_CFG_AW-1:0] cfg_rd_addr,
    input wire logic cfg_rd_valid,
    input wire logic [ILV_COEF_W-1:0] cfg_rd_data,
    // channel clocks
    output logic chan_clk_a,
    output logic chan_clk_b,
    // capture side
    input wire logic capture_ready,
    output logic ready_strobe_first_bus,
    output logic ready_strobe_first_bus_n,
    output logic ready_strobe_second_bus,
    output logic ready_strobe_second_bus_n,
    output logic [SAMPLE_W-1:0] first_bus,
    output logic [SAMPLE_W-1:0] first_bus_n,
    output logic [SAMPLE_W-1:0] second_bus,
    output logic [SAMPLE_W-1:0] second_bus_n,
    output logic reload_busy
);
    if (SAMPLE_W < 2 || SAMPLE_W > ILV_COEF_W) begin : g_bad_width
        $error("ilv_core: SAMPLE_W out of range");
    end
    if (RELOAD_CYCLES < ILV_CFG_WORDS + 2) begin : g_bad_reload
        $error("ilv_core: RELOAD_CYCLES too small");
    end

    localparam int CW = 40;
    localparam int PW = SAMPLE_W + ILV_COEF_W;

    // --------------------------------------------------------------
    // channel clock divider
    // --------------------------------------------------------------
    logic phase_reg;
    always_ff @(posedge ref_clk) begin
        phase_reg <= sys_rst ? 1'b0 : ~phase_reg;
    end
    assign chan_clk_a = phase_reg;
    assign chan_clk_b = ~phase_reg;

    // --------------------------------------------------------------
    // reload sequencer
    // --------------------------------------------------------------
    ilv_state_t state_reg, state_next;
    logic rst_n_d_reg;
    logic [ILV_CFG_AW:0] ld_cnt_reg;
    logic [CW-1:0] tmo_reg;
    logic req_out_reg;
    wire rst_rise = reload_rst_n & ~rst_n_d_reg;
    wire ld_done = cfg_rd_valid && (ld_cnt_reg == (ILV_CFG_AW+1)'(ILV_CFG_WORDS - 1));
    // the store may stall; the time budget ends the reload regardless
    wire tmo_hit = tmo_reg >= CW'(RELOAD_CYCLES - 1);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ILV_ST_HOLD: if (reload_rst_n) state_next = ILV_ST_LOAD;
            ILV_ST_LOAD: if (!reload_rst_n) state_next = ILV_ST_HOLD;
                         else if (ld_done || tmo_hit) state_next = ILV_ST_RUN;
            ILV_ST_RUN:  if (!reload_rst_n) state_next = ILV_ST_HOLD;
            default:     state_next = ILV_ST_HOLD;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= ILV_ST_HOLD;
            // idle level of the pin, so no false edge follows reset
            rst_n_d_reg <= 1'b1;
            ld_cnt_reg <= '0;
            tmo_reg <= '0;
            req_out_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rst_n_d_reg <= reload_rst_n;
            req_out_reg <= (state_next == ILV_ST_LOAD) && !(cfg_rd_valid && ld_done);
            if (state_reg != ILV_ST_LOAD || rst_rise) begin
                ld_cnt_reg <= '0;
                tmo_reg <= '0;
            end else begin
                tmo_reg <= tmo_reg + CW'(1);
                if (cfg_rd_valid) ld_cnt_reg <= ld_cnt_reg + (ILV_CFG_AW+1)'(1);
            end
        end
    end
    assign cfg_rd_req = req_out_reg && (state_reg == ILV_ST_LOAD);
    assign cfg_rd_addr = ld_cnt_reg[ILV_CFG_AW-1:0];
    assign reload_busy = (state_reg != ILV_ST_RUN);

    // --------------------------------------------------------------
    // correction coefficients
    // --------------------------------------------------------------
    logic [ILV_CFG_AW-1:0] coef_sel_reg;
    logic [ILV_COEF_W-1:0] coef_rd;
    logic [ILV_COEF_W-1:0] gain_a_reg, gain_b_reg, ofs_b_reg, skew_b_reg;
    wire mem_wr = (state_reg == ILV_ST_LOAD) && cfg_rd_valid;
    ilv_cfg_mem #(.DW(ILV_COEF_W), .AW(ILV_CFG_AW)) u_cfg_mem (
        .ref_clk(ref_clk),
        .wr_en(mem_wr),
        .wr_addr(cfg_rd_addr),
        .wr_data(cfg_rd_data),
        .rd_addr(coef_sel_reg),
        .rd_data(coef_rd)
    );
    // coefficients stream out of the memory into working registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            coef_sel_reg <= '0;
            gain_a_reg <= ILV_COEF_UNITY;
            gain_b_reg <= ILV_COEF_UNITY;
            ofs_b_reg <= '0;
            skew_b_reg <= '0;
        end else begin
            coef_sel_reg <= coef_sel_reg + ILV_CFG_AW'(1);
            if (state_reg == ILV_ST_RUN) begin
                case (coef_sel_reg - ILV_CFG_AW'(1))
                    ILV_CFG_GAIN_A: gain_a_reg <= coef_rd;
                    ILV_CFG_GAIN_B: gain_b_reg <= coef_rd;
                    ILV_CFG_OFS_B:  ofs_b_reg <= coef_rd;
                    ILV_CFG_SKEW_B: skew_b_reg <= coef_rd;
                    default: ;
                endcase
            end
        end
    end

    // --------------------------------------------------------------
    // mismatch correction datapath
    // --------------------------------------------------------------
    // offset binary to twos complement by msb inversion
    wire signed [SAMPLE_W-1:0] sa = {~conv_a_data[SAMPLE_W-1], conv_a_data[SAMPLE_W-2:0]};
    wire signed [SAMPLE_W-1:0] sb = {~conv_b_data[SAMPLE_W-1], conv_b_data[SAMPLE_W-2:0]};
    logic signed [SAMPLE_W-1:0] sa_hold_reg, sb_hold_reg, sb_prev_reg;
    logic signed [SAMPLE_W-1:0] ca_reg, cb_reg;
    logic pair_vld_reg, corr_vld_reg;

    // skew term: first-order interpolation toward the previous B sample
    wire signed [PW-1:0] pa = sa_hold_reg * $signed(gain_a_reg);
    wire signed [PW-1:0] pb = sb_hold_reg * $signed(gain_b_reg);
    wire signed [SAMPLE_W:0] db = {sb_hold_reg[SAMPLE_W-1], sb_hold_reg} - {sb_prev_reg[SAMPLE_W-1], sb_prev_reg};
    wire signed [PW:0] pk = db * $signed(skew_b_reg);
    wire signed [PW+1:0] sum_b = (PW+2)'(pb) - (PW+2)'(pk)
        + ((PW+2)'($signed(ofs_b_reg)) <<< ILV_COEF_FRAC);
    wire signed [PW-1:0] qa = pa >>> ILV_COEF_FRAC;
    wire signed [PW+1:0] qb = sum_b >>> ILV_COEF_FRAC;

    function automatic logic [SAMPLE_W-1:0] sat(input logic signed [PW+1:0] v);
        logic signed [PW+1:0] mx;
        mx = (PW+2)'((1 << (SAMPLE_W-1)) - 1);
        if (v > mx) sat = {1'b0, {(SAMPLE_W-1){1'b1}}};
        else if (v < -mx - 1) sat = {1'b1, {(SAMPLE_W-1){1'b0}}};
        else sat = v[SAMPLE_W-1:0];
    endfunction

    // A samples on the even phase, B one encode period later
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sa_hold_reg <= '0;
            sb_hold_reg <= '0;
            sb_prev_reg <= '0;
            ca_reg <= '0;
            cb_reg <= '0;
            pair_vld_reg <= 1'b0;
            corr_vld_reg <= 1'b0;
        end else begin
            if (!phase_reg) sa_hold_reg <= sa;
            if (phase_reg) begin
                sb_prev_reg <= sb_hold_reg;
                sb_hold_reg <= sb;
            end
            pair_vld_reg <= phase_reg && (state_reg == ILV_ST_RUN);
            corr_vld_reg <= pair_vld_reg;
            ca_reg <= sat((PW+2)'(qa));
            cb_reg <= sat(qb);
        end
    end

    // --------------------------------------------------------------
    // two-entry output buffer, one pair per entry
    // --------------------------------------------------------------
    logic [2*SAMPLE_W-1:0] buf_reg [0:1];
    logic wp_reg, rp_reg;
    logic [1:0] cnt_reg;
    wire buf_full = (cnt_reg == 2'h2);
    wire buf_empty = (cnt_reg == 2'h0);
    // capture logic that stalls too long loses whole pairs, never halves
    wire push = corr_vld_reg && !buf_full;
    wire pop = !buf_empty && capture_ready;
    logic [SAMPLE_W-1:0] out_a_reg, out_b_reg;
    logic strobe_reg;

    // keyed on the next state so the buses park high on the very edge that leaves run
    always_ff @(posedge ref_clk) begin
        if (sys_rst || state_next != ILV_ST_RUN) begin
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
            cnt_reg <= 2'h0;
            strobe_reg <= 1'b0;
            out_a_reg <= '1;
            out_b_reg <= '1;
        end else begin
            if (push) begin
                buf_reg[wp_reg] <= {cb_reg, ca_reg};
                wp_reg <= ~wp_reg;
            end
            if (pop) begin
                {out_b_reg, out_a_reg} <= buf_reg[rp_reg];
                rp_reg <= ~rp_reg;
            end
            cnt_reg <= cnt_reg + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
            strobe_reg <= pop;
        end
    end

    // --------------------------------------------------------------
    // differential output pairs
    // --------------------------------------------------------------
    wire hold_hi = (state_reg != ILV_ST_RUN);
    assign first_bus = out_a_reg;
    assign first_bus_n = hold_hi ? '1 : ~out_a_reg;
    assign second_bus = out_b_reg;
    assign second_bus_n = hold_hi ? '1 : ~out_b_reg;
    assign ready_strobe_first_bus = hold_hi | strobe_reg;
    assign ready_strobe_first_bus_n = hold_hi | ~strobe_reg;
    assign ready_strobe_second_bus = hold_hi | strobe_reg;
    assign ready_strobe_second_bus_n = hold_hi | ~strobe_reg;
endmodule
`default_nettype wire

// [tb/ilv_core_monitor.sv]
// ilv_core_monitor: port-level checks on the interleaved output and reload core
// assumes one ref_clk domain and sys_rst as its synchronous reset
`timescale 1ns/1ps
`default_nettype none
module ilv_core_monitor
    import ilv_pkg::*;
#(
    parameter int SAMPLE_W = ILV_SAMPLE_W,
    parameter longint RELOAD_CYCLES = ILV_RELOAD_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic reload_rst_n,
    // channel clocks and capture side
    input wire logic chan_clk_a,
    input wire logic chan_clk_b,
    input wire logic capture_ready,
    input wire logic ready_strobe_first_bus,
    input wire logic ready_strobe_first_bus_n,
    input wire logic ready_strobe_second_bus,
    input wire logic ready_strobe_second_bus_n,
    input wire logic [SAMPLE_W-1:0] first_bus,
    input wire logic [SAMPLE_W-1:0] first_bus_n,
    input wire logic [SAMPLE_W-1:0] second_bus,
    input wire logic [SAMPLE_W-1:0] second_bus_n,
    input wire logic reload_busy
);
    // --------------------------------------------------
    // helpers and properties
    // --------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic [31:0] load_cnt_reg;
    // counts only while the pin is high and the load has not finished
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !reload_rst_n || !reload_busy) begin
            load_cnt_reg <= 32'h0;
        end else begin
            load_cnt_reg <= load_cnt_reg + 32'h1;
        end
    end
    sequence s_pin_rise;
        $rose(reload_rst_n);
    endsequence
    sequence s_run_quiet;
        !reload_busy && !$past(reload_busy) && !ready_strobe_first_bus;
    endsequence
    property p_force_high;
        reload_busy |-> ready_strobe_first_bus && ready_strobe_second_bus && ready_strobe_first_bus_n
            && (&first_bus) && (&second_bus) && (&first_bus_n) && (&second_bus_n);
    endproperty
    a_force_high: assert property (p_force_high) else $error("outputs not high in reload");
    property p_pin_low;
        !reload_rst_n |=> reload_busy;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin low did not start reload");
    property p_load_start;
        s_pin_rise |-> reload_busy [*2];
    endproperty
    a_load_start: assert property (p_load_start) else $error("reload ended at pin rise");
    property p_load_bound;
        load_cnt_reg <= RELOAD_CYCLES + 4;
    endproperty
    a_load_bound: assert property (p_load_bound) else $error("reload overran its bound");
    property p_pair_lines;
        !reload_busy |-> first_bus_n == ~first_bus && second_bus_n == ~second_bus
            && ready_strobe_first_bus_n == ~ready_strobe_first_bus;
    endproperty
    a_pair_lines: assert property (p_pair_lines) else $error("complement line wrong");
    property p_strobes_match;
        !reload_busy |-> ready_strobe_first_bus == ready_strobe_second_bus;
    endproperty
    a_strobes_match: assert property (p_strobes_match) else $error("bus strobes differ");
    property p_half_rate;
        !$past(sys_rst) |-> chan_clk_a != $past(chan_clk_a) && chan_clk_a != chan_clk_b;
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("channel clocks wrong");
    property p_bus_hold;
        s_run_quiet |-> $stable(first_bus) && $stable(second_bus);
    endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("bus moved without strobe");
    property p_no_pop;
        !$past(capture_ready) && !reload_busy |-> !ready_strobe_first_bus;
    endproperty
    a_no_pop: assert property (p_no_pop) else $error("strobe while capture stalled");
endmodule
bind ilv_core ilv_core_monitor #(.SAMPLE_W(SAMPLE_W), .RELOAD_CYCLES(RELOAD_CYCLES)) u_mon (.*);
`default_nettype wire

// [tb/ilv_store_model.sv]
// ilv_store_model: nonvolatile configuration store answering the core's reads
// assumes the core holds address and request until the valid pulse
`timescale 1ns/1ps
`default_nettype none
module ilv_store_model
    import ilv_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // read port of the core
    input wire logic cfg_rd_req,
    input wire logic [ILV_CFG_AW-1:0] cfg_rd_addr,
    input wire logic [3:0] store_delay,
    input wire logic [ILV_COEF_W-1:0] store_ofs,
    output logic cfg_rd_valid,
    output logic [ILV_COEF_W-1:0] cfg_rd_data
);
    logic [3:0] wait_reg;
    // unity gains and zero skew; the B offset comes from the bench
    wire logic [ILV_COEF_W-1:0] word_sel = (cfg_rd_addr == ILV_CFG_OFS_B) ? store_ofs
        : (cfg_rd_addr == ILV_CFG_SKEW_B) ? 16'h0000 : ILV_COEF_UNITY;
    // data only means something with valid, so it churns otherwise
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !cfg_rd_req || cfg_rd_valid) begin
            wait_reg <= 4'h0;
            cfg_rd_valid <= 1'b0;
            cfg_rd_data <= sys_rst ? 16'h5A5A : ~cfg_rd_data;
        end else if (wait_reg == store_delay) begin
            cfg_rd_valid <= 1'b1;
            cfg_rd_data <= word_sel;
        end else begin
            wait_reg <= wait_reg + 4'h1;
            cfg_rd_valid <= 1'b0;
            cfg_rd_data <= ~cfg_rd_data;
        end
    end
endmodule
`default_nettype wire

// [tb/tb_ilv_core.sv]
// tb_ilv_core: scenario bench for the interleaved output and reload core
// assumes the store model on the config port and the bound monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module tb_ilv_core
    import ilv_pkg::*;
;
    // --------------------------------------------------
    // stimulus and instances
    // --------------------------------------------------
    logic ref_clk = 1'b0, sys_rst = 1'b1, reload_rst_n = 1'b1, capture_ready = 1'b1;
    logic [11:0] conv_a_data = 12'h000, conv_b_data = 12'h000, first_bus, first_bus_n, second_bus, second_bus_n;
    logic [3:0] store_delay = 4'h0;
    logic [15:0] store_ofs = 16'h0000;
    logic [1:0] cfg_rd_addr;
    logic [15:0] cfg_rd_data;
    logic cfg_rd_req, cfg_rd_valid, chan_clk_a, chan_clk_b, reload_busy;
    logic ready_strobe_first_bus, ready_strobe_first_bus_n, ready_strobe_second_bus, ready_strobe_second_bus_n;
    int err_count = 0, total_checks = 0;
    ilv_core #(.RELOAD_CYCLES(50)) DUT (.*);
    ilv_store_model u_store (.*);
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic wait_strobe();
        int n = 0;
        @(negedge ref_clk);
        while (ready_strobe_first_bus !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(ready_strobe_first_bus, 1'b1)
    endtask
    task automatic wait_ready(input int lim);
        int n = 0;
        // words shown while the strobes are parked high are not taken
        while (reload_busy !== 1'b0 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(reload_busy, 1'b0)
    endtask
    task automatic check_pair(input logic [11:0] a, input logic [11:0] b, input logic [11:0] b_ofs = 12'h000);
        @(posedge ref_clk);
        conv_a_data <= a;
        conv_b_data <= b;
        repeat (16) @(negedge ref_clk);
        wait_strobe();
        `CHK({first_bus, second_bus}, {a ^ 12'h800, (b ^ 12'h800) + b_ofs})
        `CHK({first_bus_n, ready_strobe_second_bus}, {~(a ^ 12'h800), 1'b1})
    endtask
    task automatic pin_pulse(input logic [3:0] dly);
        @(posedge ref_clk);
        reload_rst_n <= 1'b0;
        store_delay <= dly;
        repeat (40) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK({reload_busy, ready_strobe_second_bus_n, second_bus_n}, 14'h3FFF)
        @(posedge ref_clk);
        reload_rst_n <= 1'b1;
        @(negedge ref_clk);
        `CHK(reload_busy, 1'b1)
    endtask
    task automatic t_samples();
        logic [23:0] tbl [4] = '{24'h000FFF, 24'h8007FF, 24'h123ABC, 24'h7FF800};
        foreach (tbl[i]) check_pair(tbl[i][23:12], tbl[i][11:0]);
    endtask
    task automatic t_stall();
        int seen = 0;
        @(posedge ref_clk);
        capture_ready <= 1'b0;
        repeat (2) @(negedge ref_clk);
        repeat (20) begin
            @(negedge ref_clk);
            seen += (ready_strobe_first_bus === 1'b1);
        end
        `CHK(seen, 0)
        @(posedge ref_clk);
        capture_ready <= 1'b1;
        check_pair(12'h456, 12'hBCD);
    endtask
    task automatic t_offset();
        @(posedge ref_clk);
        store_ofs <= 16'h0010;
        pin_pulse(4'h0);
        wait_ready(50);
        check_pair(12'h900, 12'h900, 12'h010);
    endtask
    task wrap_up();
        if (err_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // --------------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK({ready_strobe_first_bus, first_bus, second_bus}, 25'h1FFFFFF)
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        wait_ready(20);
        t_samples();
        // slow store: four words cannot land before the load timer ends
        pin_pulse(4'hF);
        wait_ready(60);
        pin_pulse(4'h3);
        wait_ready(50);
        t_samples();
        t_stall();
        t_offset();
        wrap_up();
    end
    initial begin
        #50000;
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
